// >>> hw/epi_ctrl.sv
// external pin interrupt control register with priority, enable and event flags
// assumes a same-clock register master and asynchronous interrupt pins
`timescale 1ns/1ps
`default_nettype none
`include "epi_map.svh"

module epi_ctrl
	import epi_pkg::*;
(
	// clock and reset
	input  wire logic             core_clk,
	input  wire logic             resetn,
	// register port
	input  wire logic [`EPI_ADDR_W-1:0] regAddr,
	input  wire logic [7:0]       regWdata,
	input  wire logic             regWr,
	input  wire logic             regRd,
	output logic      [7:0]       regRdata,
	// external pins
	input  wire logic             extIrqPinA,
	input  wire logic             extIrqPinB,
	// edge selects held in another control register
	input  wire logic             pin1EdgeSelect,
	input  wire logic             pin2EdgeSelect,
	// interrupt requests
	output logic                  irqHigh,
	output logic                  irqLow
);

	// only one register is mapped; everything else reads zero
	function automatic logic isCtrlAddr(input epi_addr_t addr);
		isCtrlAddr = (addr == `EPI_ADDR_CTRL3);
	endfunction

	epi_edge_if edgeBus ();

	assign edgeBus.edgeSel[`EPI_PIN_A] = pin1EdgeSelect;
	assign edgeBus.edgeSel[`EPI_PIN_B] = pin2EdgeSelect;

	epi_edge_detect u_det (
		.core_clk (core_clk),
		.resetn   (resetn),
		.extPins  ({extIrqPinB, extIrqPinA}),
		.edgeBus  (edgeBus.det)
	);

	epi_pair_t prio_r;
	epi_pair_t en_r;
	epi_pair_t flag_r;
	epi_byte_t rdata_r;
	logic      irqHigh_r;
	logic      irqLow_r;
	epi_pair_t prio_nxt;
	epi_pair_t en_nxt;
	epi_pair_t flag_nxt;
	epi_byte_t rdata_nxt;
	logic      irqHigh_nxt;
	logic      irqLow_nxt;
	logic      ctrlWr;
	logic      ctrlRd;
	epi_pair_t wrFlags;
	epi_pair_t clrFlags;
	epi_pair_t pending;
	epi_byte_t readView;

	assign ctrlWr = regWr & isCtrlAddr(regAddr);
	assign ctrlRd = regRd & isCtrlAddr(regAddr);
	assign wrFlags = {regWdata[`EPI_FLAG_B_BIT], regWdata[`EPI_FLAG_A_BIT]};

	always_comb
	begin
		readView = `EPI_CTRL3_RST;
		readView[`EPI_PRIO_B_BIT] = prio_r[`EPI_PIN_B];
		readView[`EPI_PRIO_A_BIT] = prio_r[`EPI_PIN_A];
		readView[`EPI_EN_B_BIT]   = en_r[`EPI_PIN_B];
		readView[`EPI_EN_A_BIT]   = en_r[`EPI_PIN_A];
		readView[`EPI_FLAG_B_BIT] = flag_r[`EPI_PIN_B];
		readView[`EPI_FLAG_A_BIT] = flag_r[`EPI_PIN_A];
	end

	always_comb
	begin
		prio_nxt = prio_r;
		en_nxt   = en_r;
		if (ctrlWr)
		begin
			prio_nxt = {regWdata[`EPI_PRIO_B_BIT], regWdata[`EPI_PRIO_A_BIT]};
			en_nxt   = {regWdata[`EPI_EN_B_BIT], regWdata[`EPI_EN_A_BIT]};
		end
		// a written zero clears, a written one leaves the flag alone
		clrFlags = ctrlWr ? ~wrFlags : `EPI_PAIR_RST;
		// set ignores enables and wins over a clear
		flag_nxt = (flag_r & ~clrFlags) | edgeBus.edgeEvt;
		pending     = flag_nxt & en_nxt;
		irqHigh_nxt = |(pending & prio_nxt);
		irqLow_nxt  = |(pending & ~prio_nxt);
		// read data stand for one cycle only
		rdata_nxt = ctrlRd ? readView : `EPI_RDATA_IDLE;
	end

	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			prio_r    <= `EPI_PAIR_RST;
			en_r      <= `EPI_PAIR_RST;
			flag_r    <= `EPI_PAIR_RST;
			rdata_r   <= `EPI_RDATA_IDLE;
			irqHigh_r <= 1'b0;
			irqLow_r  <= 1'b0;
		end
		else
		begin
			prio_r    <= prio_nxt;
			en_r      <= en_nxt;
			flag_r    <= flag_nxt;
			rdata_r   <= rdata_nxt;
			irqHigh_r <= irqHigh_nxt;
			irqLow_r  <= irqLow_nxt;
		end
	end

	assign regRdata = rdata_r;
	assign irqHigh  = irqHigh_r;
	assign irqLow   = irqLow_r;

	// checks
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!resetn);

	AST_PRIO_B_WRITE: assert property (
		ctrlWr |=> prio_r[`EPI_PIN_B] == $past(regWdata[`EPI_PRIO_B_BIT]))
		else $error("pin b priority not stored");

	AST_PRIO_A_HOLD: assert property (
		ctrlWr ##1 !ctrlWr [*3] |-> prio_r[`EPI_PIN_A] == $past(regWdata[`EPI_PRIO_A_BIT], 3))
		else $error("pin a priority not held after write");

	AST_UNUSED_ZERO: assert property (
		!regRdata[`EPI_UNUSED_HI_BIT] && !regRdata[`EPI_UNUSED_LO_BIT])
		else $error("unused bit read as one");

	AST_EN_B_WRITE: assert property (
		ctrlWr |=> regRd && isCtrlAddr(regAddr) |=>
			regRdata[`EPI_EN_B_BIT] == $past(regWdata[`EPI_EN_B_BIT], 2))
		else $error("pin b enable readback wrong");

	AST_EN_A_WRITE: assert property (
		ctrlWr |=> en_r[`EPI_PIN_A] == $past(regWdata[`EPI_EN_A_BIT]))
		else $error("pin a enable not stored");

	AST_FLAG_B_SET: assert property (
		edgeBus.edgeEvt[`EPI_PIN_B] |=> flag_r[`EPI_PIN_B])
		else $error("pin b event did not set flag");

	AST_FLAG_B_CAUSE: assert property (
		$rose(flag_r[`EPI_PIN_B]) |-> $past(edgeBus.edgeEvt[`EPI_PIN_B]))
		else $error("pin b flag set without event");

	AST_FLAG_A_SET: assert property (
		edgeBus.edgeEvt[`EPI_PIN_A] ##1 ctrlRd |=> regRdata[`EPI_FLAG_A_BIT])
		else $error("pin a flag not visible on read");

	AST_FLAG_STICKY: assert property (
		flag_r[`EPI_PIN_A] && !(ctrlWr && !regWdata[`EPI_FLAG_A_BIT]) |=> flag_r[`EPI_PIN_A])
		else $error("pin a flag dropped without software clear");

	AST_FLAG_CLEAR: assert property (
		ctrlWr && !regWdata[`EPI_FLAG_B_BIT] && !edgeBus.edgeEvt[`EPI_PIN_B]
		|=> !flag_r[`EPI_PIN_B])
		else $error("pin b flag not cleared by write");

	AST_POLL_DISABLED: assert property (
		edgeBus.edgeEvt[`EPI_PIN_A] && !en_r[`EPI_PIN_A] && !ctrlWr
		|=> flag_r[`EPI_PIN_A] && !irqHigh && !irqLow || en_r[`EPI_PIN_B])
		else $error("disabled pin a event mishandled");

	AST_IRQ_LEVEL: assert property (
		$rose(flag_r[`EPI_PIN_B]) && en_r[`EPI_PIN_B] && prio_r[`EPI_PIN_B] |-> irqHigh)
		else $error("high request missing");

	AST_IRQ_CAUSE: assert property (
		irqLow |-> |(flag_r & en_r & ~prio_r))
		else $error("low request without cause");

	AST_RDATA_PULSE: assert property (
		!$past(ctrlRd) |-> regRdata == `EPI_RDATA_IDLE)
		else $error("read data outside the read cycle");

	COV_HIGH_IRQ: cover property (
		edgeBus.edgeEvt[`EPI_PIN_B] ##1 irqHigh);
	COV_LOW_IRQ: cover property (
		edgeBus.edgeEvt[`EPI_PIN_A] ##1 irqLow);
	COV_SET_AND_CLEAR: cover property (
		ctrlWr && !regWdata[`EPI_FLAG_A_BIT] && edgeBus.edgeEvt[`EPI_PIN_A]);
	COV_POLL_READ: cover property (
		flag_r[`EPI_PIN_B] && !en_r[`EPI_PIN_B] && ctrlRd);

endmodule // epi_ctrl

`default_nettype wire

// >>> hw/epi_edge_detect.sv
// synchronises the two external interrupt pins and flags the selected edge
// assumes asynchronous pins; events are one core_clk cycle long
`timescale 1ns/1ps
`default_nettype none
`include "epi_map.svh"

module epi_edge_detect
	import epi_pkg::*;
(
	// clock and reset
	input  wire logic core_clk,
	input  wire logic resetn,
	// raw pins
	input  wire logic [`EPI_PIN_CNT-1:0] extPins,
	// toward control logic
	epi_edge_if.det edgeBus
);

	epi_pair_t       sync1_r;
	epi_pair_t       sync2_r;
	epi_pair_t       prev_r;
	logic [`EPI_PRIMED_MSB:0] primed_r;
	epi_pair_t       sync1_nxt;
	epi_pair_t       sync2_nxt;
	epi_pair_t       prev_nxt;
	logic [`EPI_PRIMED_MSB:0] primed_nxt;

	// primed blocks a false edge from the reset value of the history flops
	always_comb
	begin
		sync1_nxt  = extPins;
		sync2_nxt  = sync1_r;
		prev_nxt   = sync2_r;
		primed_nxt = {primed_r[`EPI_PRIMED_MSB-1:0], 1'b1};
	end

	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			sync1_r  <= `EPI_PAIR_RST;
			sync2_r  <= `EPI_PAIR_RST;
			prev_r   <= `EPI_PAIR_RST;
			primed_r <= `EPI_PRIMED_RST;
		end
		else
		begin
			sync1_r  <= sync1_nxt;
			sync2_r  <= sync2_nxt;
			prev_r   <= prev_nxt;
			primed_r <= primed_nxt;
		end
	end

	genvar g;
	generate
		for (g = 0; g < `EPI_PIN_CNT; g++)
		begin : g_pin
			assign edgeBus.edgeEvt[g] = primed_r[`EPI_PRIMED_MSB] &
				(edgeBus.edgeSel[g] ? (sync2_r[g] & ~prev_r[g]) : (~sync2_r[g] & prev_r[g]));

			AST_EDGE_RISE: assert property (@(posedge core_clk) disable iff (!resetn)
				primed_r[`EPI_PRIMED_MSB] && edgeBus.edgeSel[g] && sync2_r[g] && !prev_r[g]
				|-> edgeBus.edgeEvt[g])
				else $error("selected rising edge not reported");

			AST_EDGE_FALL: assert property (@(posedge core_clk) disable iff (!resetn)
				edgeBus.edgeEvt[g] && !edgeBus.edgeSel[g] |-> !sync2_r[g] && prev_r[g])
				else $error("falling event without a falling edge");
		end
	endgenerate

endmodule // epi_edge_detect

`default_nettype wire

// >>> hw/epi_edge_if.sv
// edge selects toward the detector and edge events back to the control logic
// assumes one core_clk domain on both sides
`timescale 1ns/1ps
`default_nettype none

interface epi_edge_if;
	import epi_pkg::*;
	epi_pair_t edgeSel;
	epi_pair_t edgeEvt;
	modport det (input edgeSel, output edgeEvt);
	modport ctl (output edgeSel, input edgeEvt);
endinterface

`default_nettype wire

// >>> hw/epi_map.svh
// register map, field positions and reset values of the external pin interrupt control
// assumes inclusion by the package and the design modules by bare name
`ifndef EPI_MAP_SVH
`define EPI_MAP_SVH

`define EPI_ADDR_W        4
`define EPI_ADDR_CTRL3    4'h0
`define EPI_CTRL3_RST     8'h00
`define EPI_RDATA_IDLE    8'h00
`define EPI_PAIR_RST      2'h0
`define EPI_PRIMED_RST    3'h0
`define EPI_PRIMED_MSB    2

`define EPI_PRIO_B_BIT    7
`define EPI_PRIO_A_BIT    6
`define EPI_UNUSED_HI_BIT 5
`define EPI_EN_B_BIT      4
`define EPI_EN_A_BIT      3
`define EPI_UNUSED_LO_BIT 2
`define EPI_FLAG_B_BIT    1
`define EPI_FLAG_A_BIT    0

`define EPI_PIN_A         0
`define EPI_PIN_B         1
`define EPI_PIN_CNT       2

`endif

// >>> hw/epi_pkg.sv
// types shared by the external pin interrupt control modules
// assumes epi_map.svh on the include path
`include "epi_map.svh"

package epi_pkg;
	typedef logic [7:0]             epi_byte_t;
	typedef logic [`EPI_PIN_CNT-1:0] epi_pair_t;
	typedef logic [`EPI_ADDR_W-1:0]  epi_addr_t;
endpackage

// >>> tb/epi_pin_model.sv
// board-side model driving the two external interrupt pins
// assumes the bench calls set_pin from one process at a time
`timescale 1ns/1ps
`default_nettype none

module epi_pin_model
(
	// clock
	input  wire logic core_clk,
	// pins
	output logic      pinA,
	output logic      pinB
);
	initial
	begin
		pinA = 1'b0;
		pinB = 1'b0;
	end

	// level moves just after an edge and holds well over two cycles
	task automatic set_pin(input int idx, input logic lvl);
		@(posedge core_clk);
		if (idx == 0)
			pinA <= lvl;
		else
			pinB <= lvl;
		repeat (5) @(posedge core_clk);
	endtask
endmodule // epi_pin_model

`default_nettype wire

// >>> tb/external_pin_irq_control_tb.sv
// self-checking bench for the external pin interrupt control register
// assumes epi_ctrl at address 4'h0 and the pin model beside it
`timescale 1ns/1ps
`default_nettype none

module external_pin_irq_control_tb;
	import epi_pkg::*;
	logic      core_clk;
	logic      resetn;
	logic      regWr;
	logic      regRd;
	logic      selA;
	logic      selB;
	logic      pinA;
	logic      pinB;
	logic      irqHigh;
	logic      irqLow;
	epi_addr_t regAddr;
	epi_byte_t regWdata;
	epi_byte_t regRdata;
	epi_byte_t d;
	int        mismatches;
	int        total_checks;
	int        cycles;

	epi_ctrl dut (.core_clk(core_clk), .resetn(resetn), .regAddr(regAddr),
		.regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
		.extIrqPinA(pinA), .extIrqPinB(pinB), .pin1EdgeSelect(selA),
		.pin2EdgeSelect(selB), .irqHigh(irqHigh), .irqLow(irqLow));
	epi_pin_model pins (.core_clk(core_clk), .pinA(pinA), .pinB(pinB));

	initial
	begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// hang guard, far above the few hundred cycles the run needs
	always @(posedge core_clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			mismatches = mismatches + 1;
			tally_and_finish();
		end
	end

	task automatic chk(input string nm, input epi_byte_t exp, input epi_byte_t got);
		total_checks = total_checks + 1;
		if (got !== exp)
		begin
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
			mismatches = mismatches + 1;
		end
	endtask

	task automatic wr(input epi_addr_t a, input epi_byte_t v);
		@(posedge core_clk);
		regAddr  <= a;
		regWdata <= v;
		regWr    <= 1'b1;
		@(posedge core_clk);
		regWr    <= 1'b0;
	endtask

	// read data stand only in the cycle after the strobe
	task automatic rd(input epi_addr_t a, output epi_byte_t v);
		@(posedge core_clk);
		regAddr <= a;
		regRd   <= 1'b1;
		@(posedge core_clk);
		regRd   <= 1'b0;
		#1 v = regRdata;
	endtask

	// write then read with no idle cycle between the strobes
	task automatic wr_rd(input epi_addr_t a, input epi_byte_t v, output epi_byte_t r);
		@(posedge core_clk);
		regAddr  <= a;
		regWdata <= v;
		regWr    <= 1'b1;
		@(posedge core_clk);
		regWr    <= 1'b0;
		regRd    <= 1'b1;
		@(posedge core_clk);
		regRd    <= 1'b0;
		#1 r = regRdata;
	endtask

	task automatic irq_now(input epi_byte_t exp);
		repeat (2) @(posedge core_clk);
		#1 chk("irq lines", exp, {6'h00, irqHigh, irqLow});
	endtask

	task automatic set_sel(input int p, input logic s);
		@(posedge core_clk);
		if (p == 0)
			selA <= s;
		else
			selB <= s;
	endtask

	task automatic test_regs();
		rd(4'h0, d);
		chk("reset value", 8'h00, d);
		for (int i = 0; i < 8; i++)
		begin
			wr(4'h0, 8'h01 << i);
			rd(4'h0, d);
			chk("single bit", (8'h01 << i) & 8'hD8, d);
		end
		wr(4'h0, 8'hFF);
		rd(4'h0, d);
		chk("all ones", 8'hD8, d);
		@(posedge core_clk);
		#1 chk("read data idle", 8'h00, regRdata);
		wr(4'h1, 8'h00);
		rd(4'h0, d);
		chk("unmapped write", 8'hD8, d);
		rd(4'h1, d);
		chk("unmapped read", 8'h00, d);
		wr_rd(4'h0, 8'h10, d);
		chk("write then read", 8'h10, d);
		wr(4'h0, 8'h00);
	endtask

	task automatic test_edges();
		for (int p = 0; p < 2; p++)
			for (int s = 0; s < 2; s++)
			begin
				set_sel(p, s[0]);
				pins.set_pin(p, s[0]);
				wr(4'h0, 8'h00);
				pins.set_pin(p, !s[0]);
				rd(4'h0, d);
				chk("wrong edge", 8'h00, d);
				pins.set_pin(p, s[0]);
				repeat (20) @(posedge core_clk);
				rd(4'h0, d);
				chk("edge flag", 8'h01 << p, d);
				irq_now(8'h00);
			end
	endtask

	task automatic test_irq();
		epi_byte_t en;
		epi_byte_t pr;
		for (int p = 0; p < 2; p++)
			for (int q = 0; q < 2; q++)
			begin
				en = (p == 0) ? 8'h08 : 8'h10;
				pr = (q == 0) ? 8'h00 : ((p == 0) ? 8'h40 : 8'h80);
				set_sel(p, 1'b1);
				wr(4'h0, 8'h00);
				pins.set_pin(p, 1'b0);
				pins.set_pin(p, 1'b1);
				irq_now(8'h00);
				wr(4'h0, 8'h03 | en | pr);
				irq_now(q ? 8'h02 : 8'h01);
				// clearing the flag must drop the request
				wr(4'h0, (8'h03 & ~(8'h01 << p)) | en | pr);
				irq_now(8'h00);
				// enabled ahead of the edge: the event alone raises the request
				pins.set_pin(p, 1'b0);
				pins.set_pin(p, 1'b1);
				irq_now(q ? 8'h02 : 8'h01);
			end
	endtask

	// an event beside a clearing write, and a read right behind an event
	task automatic test_race();
		set_sel(0, 1'b1);
		wr(4'h0, 8'h00);
		pins.set_pin(0, 1'b0);
		fork
			pins.set_pin(0, 1'b1);
			begin
				repeat (2) @(posedge core_clk);
				wr(4'h0, 8'h00);
			end
		join
		rd(4'h0, d);
		chk("set beats clear", 8'h01, d);
		wr(4'h0, 8'h00);
		pins.set_pin(0, 1'b0);
		fork
			pins.set_pin(0, 1'b1);
			begin
				repeat (3) @(posedge core_clk);
				rd(4'h0, d);
			end
		join
		chk("flag on the next read", 8'h01, d);
	endtask

	// pins held high through a reset must not leave a false edge behind
	task automatic test_reset();
		wr(4'h0, 8'hDB);
		irq_now(8'h02);
		@(posedge core_clk);
		resetn <= 1'b0;
		repeat (4) @(posedge core_clk);
		resetn <= 1'b1;
		irq_now(8'h00);
		rd(4'h0, d);
		chk("after reset", 8'h00, d);
		pins.set_pin(1, 1'b0);
		pins.set_pin(1, 1'b1);
		rd(4'h0, d);
		chk("edge after reset", 8'h02, d);
	endtask

	initial
	begin
		resetn       = 1'b0;
		regWr        = 1'b0;
		regRd        = 1'b0;
		regAddr      = 4'h0;
		regWdata     = 8'h00;
		selA         = 1'b0;
		selB         = 1'b0;
		mismatches   = 0;
		total_checks = 0;
		cycles       = 0;
		repeat (16) @(posedge core_clk);
		resetn <= 1'b1;
		test_regs();
		test_edges();
		test_irq();
		test_race();
		test_reset();
		tally_and_finish();
	end
endmodule // external_pin_irq_control_tb

`default_nettype wire
